// File: verilog/upper_map_pkg.sv
/*
  Constants for the upper transceiver register map: immediate addresses,
  field positions, reset values and the one-hot access kinds.
  Assumes the addresses arrive already stripped of the ULPI command bits.
*/
`default_nettype none

package upper_map_pkg;

  localparam logic [7:0] ADDR_EVENT_LATCH = 8'h14;
  localparam logic [7:0] ADDR_LINE_DEBUG  = 8'h15;
  localparam logic [7:0] ADDR_SCRATCH_WR  = 8'h16;
  localparam logic [7:0] ADDR_SCRATCH_SET = 8'h17;
  localparam logic [7:0] ADDR_SCRATCH_CLR = 8'h18;
  localparam logic [7:0] ADDR_UNIMP_LO    = 8'h19;
  localparam logic [7:0] ADDR_UNIMP_HI    = 8'h2e;
  localparam logic [7:0] ADDR_EXT_PTR     = 8'h2f;
  localparam logic [7:0] ADDR_VENDOR_LO   = 8'h30;
  localparam logic [7:0] ADDR_PWR_WR      = 8'h3d;
  localparam logic [7:0] ADDR_PWR_SET     = 8'h3e;
  localparam logic [7:0] ADDR_PWR_CLR     = 8'h3f;
  localparam logic [7:0] ADDR_EXT_LIMIT   = 8'h40;

  localparam int NUM_SOURCES = 5;
  localparam int SRC_ID_GROUND   = 4;
  localparam int SRC_SESSION_END_COMPARATOR    = 3;
  localparam int SRC_SESS_VALID  = 2;
  localparam int SRC_VBUS_VALID  = 1;
  localparam int SRC_HOST_DISCONNECT_DETECTOR = 0;
  localparam int LINE_STATE_W    = 2;

  localparam int PWR_BVALID_FALL = 3;
  localparam int PWR_BVALID_RISE = 2;

  localparam logic [7:0] EVENT_LATCH_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET     = 8'h00;
  localparam logic [7:0] POWER_CTRL_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO         = 8'h00;

  localparam int SETTLE_CYCLES = 3;

  typedef enum logic [3:0]
  {
    OP_NONE  = 4'b0001,
    OP_WRITE = 4'b0010,
    OP_SET   = 4'b0100,
    OP_CLEAR = 4'b1000
  } op_kind_t;

endpackage

`default_nettype wire

// File: verilog/edge_event_detect.sv
/*
  Two-flop synchroniser with edge detection for a group of slow pins.
  Assumes the inputs are asynchronous levels; edges are held off until
  the synchroniser has settled after reset.
*/
`timescale 1ns/1ps
`default_nettype none

module edge_event_detect
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  import upper_map_pkg::*;

  logic [WIDTH-1:0]         meta;
  logic [WIDTH-1:0]         prev;
  logic [SETTLE_CYCLES-1:0] settle;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta  <= '0;
      level <= '0;
      prev  <= '0;
    end
    else
    begin
      meta  <= raw;
      level <= meta;
      prev  <= level;
    end
  end

  // no false edge from the reset value of prev
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      settle <= '0;
    else
      settle <= {settle[SETTLE_CYCLES-2:0], 1'b1};
  end

  assign rise = settle[SETTLE_CYCLES-1] ? (level & ~prev) : '0;
  assign fall = settle[SETTLE_CYCLES-1] ? (~level & prev) : '0;

endmodule

`default_nettype wire

// File: verilog/ulpi_upper_regs.sv
/*
  Upper part of the transceiver register map: event latch, line state
  debug, scratch byte, extended pointer and power control.
  Assumes the ULPI engine presents one decoded access per strobe, with
  reg_ext high when the access came through the extended pointer.
*/
`timescale 1ns/1ps
`default_nettype none

module ulpi_upper_regs
(
  input  wire logic                             ref_clk,
  input  wire logic                             reset_n,
  input  wire logic                             reg_rd,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_ext,
  input  wire logic [7:0]                       reg_addr,
  input  wire logic [7:0]                       reg_wdata,
  output logic      [7:0]                       reg_rdata,
  output logic                                  reg_rdata_valid,
  input  wire logic                             id_pin_grounded,
  input  wire logic                             session_end_comparator,
  input  wire logic                             session_valid_comparator,
  input  wire logic                             vbus_valid_comparator,
  input  wire logic                             host_disconnect_detector,
  input  wire logic                             bvalid_in,
  input  wire logic [upper_map_pkg::LINE_STATE_W-1:0] line_state_in,
  input  wire logic [upper_map_pkg::NUM_SOURCES-1:0]  rising_edge_event_enable,
  input  wire logic [upper_map_pkg::NUM_SOURCES-1:0]  falling_edge_event_enable,
  input  wire logic                             low_power_mode,
  output logic      [upper_map_pkg::NUM_SOURCES-1:0]  source_status,
  output logic      [7:0]                       otg_event_latch,
  output logic      [7:0]                       power_control,
  output logic                                  alt_int_rxcmd_req
);
  import upper_map_pkg::*;

  logic [NUM_SOURCES-1:0]  src_raw;
  logic [NUM_SOURCES-1:0]  src_rise;
  logic [NUM_SOURCES-1:0]  src_fall;
  logic [NUM_SOURCES-1:0]  ev_set;
  logic [LINE_STATE_W-1:0] line_state;
  logic                    bvalid_level;
  logic                    bvalid_rise;
  logic                    bvalid_fall;
  logic [7:0]              scratch_byte;
  logic                    hit;
  logic                    rd_hit;
  logic                    wr_hit;
  logic                    latch_read;
  logic                    low_power_q;
  logic                    low_power_entry;
  logic [7:0]              next_rdata;

  assign src_raw[SRC_ID_GROUND]   = id_pin_grounded;
  assign src_raw[SRC_SESSION_END_COMPARATOR]    = session_end_comparator;
  assign src_raw[SRC_SESS_VALID]  = session_valid_comparator;
  assign src_raw[SRC_VBUS_VALID]  = vbus_valid_comparator;
  assign src_raw[SRC_HOST_DISCONNECT_DETECTOR] = host_disconnect_detector;

  edge_event_detect #(.WIDTH(NUM_SOURCES)) u_src_sync
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .raw     (src_raw),
    .level   (source_status),
    .rise    (src_rise),
    .fall    (src_fall)
  );

  edge_event_detect #(.WIDTH(1)) u_bvalid_sync
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .raw     (bvalid_in),
    .level   (bvalid_level),
    .rise    (bvalid_rise),
    .fall    (bvalid_fall)
  );

  edge_event_detect #(.WIDTH(LINE_STATE_W)) u_line_sync
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .raw     (line_state_in),
    .level   (line_state),
    .rise    (),
    .fall    ()
  );

  // 2Fh immediate is only a pointer; 40h and up in the extended set are
  // dead space, so neither may touch a register
  function automatic logic addr_hit(input logic [7:0] a, input logic ext);
    if (ext)
      addr_hit = (a < ADDR_EXT_LIMIT);
    else
      addr_hit = (a < ADDR_EXT_LIMIT) && (a != ADDR_EXT_PTR);
  endfunction

  // triple of addresses: base writes, base+1 sets, base+2 clears
  function automatic op_kind_t op_of(input logic [7:0] a,
                                     input logic [7:0] base);
    if (a == base)
      op_of = OP_WRITE;
    else if (a == base + 8'h01)
      op_of = OP_SET;
    else if (a == base + 8'h02)
      op_of = OP_CLEAR;
    else
      op_of = OP_NONE;
  endfunction

  function automatic logic [7:0] apply_op(input op_kind_t k,
                                          input logic [7:0] old,
                                          input logic [7:0] d);
    case (k)
      OP_WRITE: apply_op = d;
      OP_SET:   apply_op = old | d;
      OP_CLEAR: apply_op = old & ~d;
      default:  apply_op = old;
    endcase
  endfunction

  assign hit        = addr_hit(reg_addr, reg_ext);
  assign rd_hit     = reg_rd && hit;
  assign wr_hit     = reg_wr && hit;
  assign latch_read = rd_hit && (reg_addr == ADDR_EVENT_LATCH);

  // unmasked edges only
  assign ev_set = (src_rise & rising_edge_event_enable)
                | (src_fall & falling_edge_event_enable);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      low_power_q <= 1'b0;
    else
      low_power_q <= low_power_mode;
  end

  assign low_power_entry = low_power_mode && !low_power_q;

  // set beats either clear so a racing edge is never dropped
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      otg_event_latch <= EVENT_LATCH_RESET;
    else if (latch_read || low_power_entry)
      otg_event_latch <= {3'b000, ev_set};
    else
      otg_event_latch <= otg_event_latch | {3'b000, ev_set};
  end

  // scratch feeds nothing but the read path
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      scratch_byte <= SCRATCH_RESET;
    else if (wr_hit)
      scratch_byte <= apply_op(op_of(reg_addr, ADDR_SCRATCH_WR),
                               scratch_byte, reg_wdata);
  end

  // reserved bits stored as written; the link keeps them zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      power_control <= POWER_CTRL_RESET;
    else if (wr_hit)
      power_control <= apply_op(op_of(reg_addr, ADDR_PWR_WR),
                                power_control, reg_wdata);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      alt_int_rxcmd_req <= 1'b0;
    else
      alt_int_rxcmd_req <= (power_control[PWR_BVALID_FALL] && bvalid_fall)
                        || (power_control[PWR_BVALID_RISE] && bvalid_rise);
  end

  always_comb
  begin
    next_rdata = READ_ZERO;
    if (!hit)
      next_rdata = READ_ZERO;
    else if (reg_addr == ADDR_EVENT_LATCH)
      next_rdata = otg_event_latch;
    else if (reg_addr == ADDR_LINE_DEBUG)
      next_rdata = {6'b000000, line_state};
    else if (reg_addr >= ADDR_SCRATCH_WR && reg_addr <= ADDR_SCRATCH_CLR)
      next_rdata = scratch_byte;
    else if (reg_addr >= ADDR_PWR_WR && reg_addr <= ADDR_PWR_CLR)
      next_rdata = power_control;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata       <= READ_ZERO;
      reg_rdata_valid <= 1'b0;
    end
    else
    begin
      reg_rdata_valid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  default clocking main_cb @(posedge ref_clk);
  endclocking

  default disable iff (!reset_n);

  sequence latch_read_quiet;
    latch_read && (ev_set == '0);
  endsequence

  sequence bvalid_drop_armed;
    power_control[PWR_BVALID_FALL] && bvalid_fall;
  endsequence

  AST_LATCH_SET: assert property (
    (ev_set != '0) |=> ((otg_event_latch[NUM_SOURCES-1:0] & $past(ev_set))
                        == $past(ev_set)))
    else $error("enabled edge did not set its latch bit");

  AST_READ_CLEARS: assert property (
    latch_read_quiet |=> (otg_event_latch == 8'h00)
                         && reg_rdata == $past(otg_event_latch))
    else $error("latch read did not return and clear the byte");

  AST_LOW_POWER_CLEAR: assert property (
    (low_power_mode && !low_power_q && ev_set == '0)
      |=> (otg_event_latch == 8'h00))
    else $error("low-power entry left latch bits set");

  AST_MASKED_EDGE: assert property (
    (!latch_read && !low_power_entry && ev_set == '0)
      |=> $stable(otg_event_latch))
    else $error("latch changed without an enabled edge");

  AST_RACE_KEPT: assert property (
    (latch_read && ev_set != '0)
      |=> (otg_event_latch == {3'b000, $past(ev_set)}))
    else $error("event lost when racing a latch read");

  AST_LATCH_RESERVED: assert property (
    otg_event_latch[7:NUM_SOURCES] == '0)
    else $error("reserved latch bits nonzero");

  AST_DEBUG_READ: assert property (
    (rd_hit && reg_addr == ADDR_LINE_DEBUG)
      |=> reg_rdata_valid && reg_rdata == {6'b000000, $past(line_state)})
    else $error("debug read returned wrong line state");

  AST_SCRATCH_SET: assert property (
    (wr_hit && reg_addr == ADDR_SCRATCH_SET)
      |=> scratch_byte == ($past(scratch_byte) | $past(reg_wdata)))
    else $error("scratch set did not OR in data");

  AST_SCRATCH_CLR: assert property (
    (wr_hit && reg_addr == ADDR_SCRATCH_CLR)
      |=> scratch_byte == ($past(scratch_byte) & ~$past(reg_wdata)))
    else $error("scratch clear did not remove data bits");

  AST_UNIMP_NO_EFFECT: assert property (
    (reg_wr && reg_addr >= ADDR_UNIMP_LO && reg_addr <= ADDR_EXT_PTR)
      |=> $stable(scratch_byte) && $stable(power_control))
    else $error("unimplemented address changed a register");

  AST_UNIMP_READ_ZERO: assert property (
    (reg_rd && !reg_ext && reg_addr == ADDR_EXT_PTR) |=> reg_rdata == 8'h00)
    else $error("pointer address did not read zero");

  AST_EXT_MAP: assert property (
    (reg_rd && reg_ext && reg_addr == ADDR_PWR_WR)
      |=> reg_rdata == $past(power_control))
    else $error("extended read not mapped to immediate register");

  AST_PWR_WRITE: assert property (
    (wr_hit && reg_addr == ADDR_PWR_WR) |=> power_control == $past(reg_wdata))
    else $error("power control write not stored");

  AST_BVALID_FALL: assert property (
    bvalid_drop_armed |=> alt_int_rxcmd_req)
    else $error("no alternate-interrupt request on session drop");

  AST_BVALID_QUIET: assert property (
    !(bvalid_rise || bvalid_fall) |=> !alt_int_rxcmd_req)
    else $error("alternate-interrupt request without an edge");

  AST_BVALID_RISE: assert property (
    (power_control[PWR_BVALID_RISE] && bvalid_rise) |=> alt_int_rxcmd_req)
    else $error("no alternate-interrupt request on session rise");

endmodule

`default_nettype wire

// File: test/link_model.sv
/*
  Behavioural link controller driving the register port of the upper map.
  Assumes one clock ref_clk; tasks are called from the bench between edges.
*/
`timescale 1ns/1ps
`default_nettype none

module link_model
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic            reg_ext,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rdata_valid
);
  // released lines show the inverse so a stale value never passes
  initial
  begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_ext = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic ext, input logic [7:0] addr,
                    input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (ext && addr >= 8'h40) return;
    if (addr >= 8'h3d && addr <= 8'h3f) d = data & 8'h0c;
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_ext <= ext;
    reg_addr <= addr;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_ext <= ~ext;
    reg_addr <= ~addr;
    reg_wdata <= ~d;
  endtask

  // latch reads are optional for a real link; done here only to observe
  task automatic rd(input logic ext, input logic [7:0] addr,
                    output logic [7:0] data, output logic ok);
    data = 8'h00;
    ok = 1'b1;
    if (ext && addr >= 8'h40) return;
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_ext <= ext;
    reg_addr <= addr;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_ext <= ~ext;
    reg_addr <= ~addr;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge ref_clk);
      if (reg_rdata_valid === 1'b1)
      begin
        data = reg_rdata;
        ok = 1'b1;
      end
    end
  endtask
endmodule

`default_nettype wire

// File: test/tb_top.sv
/*
  Self-checking bench for the upper register map.
  Assumes link_model drives the register port; pins are driven here.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import upper_map_pkg::*;
  typedef struct packed
  {
    logic       wext;
    logic [7:0] wa;
    logic [7:0] wd;
    logic       rext;
    logic [7:0] ra;
    logic [7:0] exp;
  } row_t;
  localparam row_t ROWS [14] = '{
    '{1'b0, 8'h16, 8'ha5, 1'b0, 8'h16, 8'ha5},
    '{1'b0, 8'h17, 8'h0f, 1'b0, 8'h17, 8'haf},
    '{1'b0, 8'h18, 8'ha0, 1'b0, 8'h18, 8'h0f},
    '{1'b0, 8'h3d, 8'h0c, 1'b0, 8'h3e, 8'h0c},
    '{1'b0, 8'h3f, 8'h04, 1'b0, 8'h3f, 8'h08},
    '{1'b0, 8'h3e, 8'h04, 1'b0, 8'h3d, 8'h0c},
    '{1'b0, 8'h20, 8'hff, 1'b0, 8'h20, 8'h00},
    '{1'b0, 8'h2e, 8'hff, 1'b0, 8'h16, 8'h0f},
    '{1'b0, 8'h19, 8'hff, 1'b0, 8'h2f, 8'h00},
    '{1'b0, 8'h30, 8'hff, 1'b0, 8'h3c, 8'h00},
    '{1'b1, 8'h16, 8'h5a, 1'b1, 8'h17, 8'h5a},
    '{1'b1, 8'h3f, 8'h08, 1'b1, 8'h3d, 8'h04},
    '{1'b0, 8'h14, 8'hff, 1'b0, 8'h14, 8'h00},
    '{1'b0, 8'h15, 8'hff, 1'b1, 8'h15, 8'h02}};

  logic       ref_clk = 1'b0;
  logic       reset_n;
  logic       reg_rd, reg_wr, reg_ext, reg_rdata_valid, bvalid_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, otg_event_latch, power_control;
  logic [4:0] src, rise_en, fall_en, source_status;
  logic [1:0] line_state_in;
  logic       low_power_mode, alt_int_rxcmd_req;
  logic [7:0] d1, d2;
  int         num_errors = 0;
  int         checked = 0;
  int         alt_count = 0;
  int         base;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (alt_int_rxcmd_req === 1'b1) alt_count <= alt_count + 1;

  link_model link (.ref_clk(ref_clk), .reset_n(reset_n), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_ext(reg_ext), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid));

  ulpi_upper_regs uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_ext(reg_ext),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .id_pin_grounded(src[4]),
    .session_end_comparator(src[3]), .session_valid_comparator(src[2]),
    .vbus_valid_comparator(src[1]), .host_disconnect_detector(src[0]),
    .bvalid_in(bvalid_in), .line_state_in(line_state_in),
    .rising_edge_event_enable(rise_en),
    .falling_edge_event_enable(fall_en), .low_power_mode(low_power_mode),
    .source_status(source_status), .otg_event_latch(otg_event_latch),
    .power_control(power_control), .alt_int_rxcmd_req(alt_int_rxcmd_req));

  task automatic report_and_stop();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // a read that never answers ends the run as a failure
  task automatic rd(input logic ext, input logic [7:0] a,
                    output logic [7:0] d);
    logic ok;
    link.rd(ext, a, d, ok);
    if (ok !== 1'b1)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask

  task automatic rdchk(input logic ext, input logic [7:0] a,
                       input logic [7:0] exp);
    logic [7:0] d;
    rd(ext, a, d);
    check("rdata", d, exp);
  endtask

  initial
  begin
    reset_n = 1'b0;
    src = 5'h00;
    rise_en = 5'h1f;
    fall_en = 5'h1f;
    bvalid_in = 1'b0;
    line_state_in = 2'b10;
    low_power_mode = 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check("valid", {7'h00, reg_rdata_valid}, 8'h00);
    check("latch", otg_event_latch, EVENT_LATCH_RESET);
    check("power", power_control, POWER_CTRL_RESET);
    rdchk(1'b0, 8'h16, 8'h00);
    rdchk(1'b0, 8'h3d, 8'h00);
    foreach (ROWS[r])
    begin
      link.wr(ROWS[r].wext, ROWS[r].wa, ROWS[r].wd);
      rdchk(ROWS[r].rext, ROWS[r].ra, ROWS[r].exp);
      // also
    end
    // register traffic above left power control at 04h and the latch clear
    check("power", power_control, 8'h04);
    check("latch", otg_event_latch, 8'h00);
    line_state_in <= 2'b01;
    repeat (4) @(posedge ref_clk);
    rdchk(1'b0, 8'h15, 8'h01);
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 5; i++)
      begin
        src[i] <= ~src[i];
        repeat (6) @(posedge ref_clk);
        check("status", {3'h0, source_status}, {3'h0, src});
        check("latch", otg_event_latch, 8'h01 << i);
        rdchk(1'b0, 8'h14, 8'h01 << i);
        check("latch", otg_event_latch, 8'h00);
      end
    rise_en <= 5'h1b;
    src[2] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("masked", otg_event_latch, 8'h00);
    src[2] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rdchk(1'b0, 8'h14, 8'h04);
    rise_en <= 5'h1f;
    src[0] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    low_power_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("lowpower", otg_event_latch, 8'h00);
    low_power_mode <= 1'b0;
    // events landing near a latch read must not vanish
    for (int d = 0; d < 6; d++)
    begin
      src[1] <= ~src[1];
      repeat (d) @(posedge ref_clk);
      rd(1'b0, 8'h14, d1);
      repeat (6) @(posedge ref_clk);
      rd(1'b0, 8'h14, d2);
      check("race", (d1 | d2) & 8'h02, 8'h02);
    end
    // debug-only edge enables; link would normally use the comparator
    for (int k = 0; k < 4; k++)
    begin
      if (k % 2 == 0) link.wr(1'b0, 8'h3d, (k < 2) ? 8'h08 : 8'h04);
      base = alt_count;
      bvalid_in <= ~bvalid_in;
      repeat (8) @(posedge ref_clk);
      check("alt_int", 8'(alt_count - base), (k == 1 || k == 2) ? 8'h01
            : 8'h00);
    end
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("power", power_control, 8'h00);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdchk(1'b0, 8'h16, 8'h00);
    rdchk(1'b0, 8'h3f, 8'h00);
    report_and_stop();
  end
endmodule

`default_nettype wire
